// file: rtl/tsl_pkg.sv
/*
 Package of the torque and speed limit block: register map, field positions,
 reset values, ranges and the carrier types.
 Assumes 16-bit signed drive quantities scaled so that 1000 counts is 100 %.
*/
package tsl_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_SPD_LIM = 12'h004;
   localparam logic [11:0] OFS_SPD_BIAS = 12'h008;
   localparam logic [11:0] OFS_SPD_COMM = 12'h00C;
   localparam logic [11:0] OFS_TLIM = 12'h010;
   localparam logic [11:0] OFS_AIN_GAIN = 12'h020;
   localparam logic [11:0] OFS_POS_FREQ = 12'h024;
   localparam logic [11:0] OFS_POS_OFS = 12'h028;
   localparam logic [11:0] OFS_STATUS = 12'h02C;
   localparam logic [11:0] OFS_TABLE = 12'h080;
   localparam logic [11:0] OFS_TABLE_END = 12'h0FC;
   // Field positions.
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_SRC_LSB = 1;
   localparam int CTRL_POS_MODE_BIT = 3;
   localparam int CTRL_FUNC_LSB = 8;
   localparam int STAT_OVER_BIT = 16;
   localparam int STAT_UNDER_BIT = 17;
   localparam int STAT_CLAMP_BIT = 18;
   localparam int STAT_QUAD_LSB = 20;
   // Ranges, in 0.1 % or 0.1 Hz or pulse counts.
   localparam int SPD_MAX = 1200;
   localparam int TLIM_MAX = 3000;
   localparam int POS_FREQ_MIN = 1;
   localparam int POS_FREQ_MAX = 1000;
   localparam int POS_MAX = 9999;
   localparam int OFS_MAX = 9999;
   // Reset values.
   localparam logic [15:0] TLIM_RST = 16'h05DC;
   localparam logic [15:0] GAIN_RST = 16'h0400;
   localparam logic [15:0] POS_FREQ_RST = 16'h0064;
   // Scaling: gain 1024 is unity, speed error gain is 2**3.
   localparam int GAIN_SHIFT = 10;
   localparam int SPD_LOOP_SHIFT = 3;
   // Auxiliary input function codes.
   localparam logic [4:0] FUNC_TLIM_POS = 5'h0B;
   localparam logic [4:0] FUNC_TLIM_NEG = 5'h0C;
   localparam logic [4:0] FUNC_TLIM_REGEN = 5'h0D;
   localparam logic [4:0] FUNC_TLIM_ALL = 5'h0E;
   localparam logic [4:0] FUNC_TCOMP = 5'h10;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      SRC_ANALOG = 2'b00,
      SRC_STORED = 2'b01,
      SRC_COMM = 2'b10
   } src_t;

   typedef struct packed {
      logic torque_mode;
      src_t src;
      logic pos_index_lock;
      logic [4:0] aux_func;
      logic signed [15:0] spd_lim;
      logic signed [15:0] spd_bias;
      logic signed [15:0] spd_comm;
      logic [3:0][15:0] tlim;
      logic [15:0] ain_gain;
      logic [15:0] pos_freq;
      logic [15:0] pos_offset;
   } cfg_t;

   typedef struct packed {
      logic signed [15:0] motor_speed;
      logic signed [15:0] torque_ref;
      logic signed [15:0] aux_analog_input;
      logic signed [15:0] ai_speed_level;
   } drive_in_t;

   typedef struct packed {
      logic signed [15:0] turns;
      logic signed [15:0] pulses;
   } pos_entry_t;
endpackage

// file: rtl/torque_speed_limit_position_cfg.sv
/*
 Torque supervision with speed window, quadrant torque limits, analog torque
 compensation and the sixteen-section position table, behind AXI4-Lite.
 Assumes one clock, synchronous inputs and an AXI4-Lite master.
*/
// Functional notes
// - Control bit selects speed regulation at 0, torque regulation at 1.
// - Speed limit source: 0 analog, 1 stored value, 2 serial link value.
// - Torque mode speed window spans minus bias to limit plus bias.
// - Inside the window the torque command follows the torque reference.
// - Above the window the limiter commands negative torque.
// - Below the window the limiter commands forward torque.
// - Function code 16 makes the auxiliary input a signed torque compensation.
// - Positive compensation adds positive torque to the command.
// - Four torque limits, each 0 to 300 percent of rated torque.
// - Quadrants I to IV use forward, forward regen, reverse, reverse regen limits.
// - Torque limiting overrides regulator output and compensation in speed mode.
// - Codes 11 to 14 choose which limits the analog input sets.
// - Code 12 applies the analog limit in quadrants III and IV.
// - Code 13 applies the analog limit in quadrants II and IV.
// - Code 14 applies the analog limit in all quadrants.
// - Full-scale input gives 100 percent at unity gain, scaled by gain.
// - Position move frequency settable from 0.1 to 100 Hz.
// - Sixteen sections of signed turns and pulses, each within 9999.
// - Position mode select bit and an offset of 0 to 9999 pulses.
`timescale 1ns/100ps
module torque_speed_limit_position_cfg
   import tsl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire drive_in_t drv,
   input wire logic [3:0] pos_section,
   output logic torque_mode,
   output logic signed [15:0] torque_cmd,
   output pos_entry_t pos_entry,
   output logic [15:0] pos_max_freq,
   output logic [15:0] pos_offset,
   output logic pos_index_lock
);
   cfg_t cfg, next_cfg;
   logic signed [15:0] turns [16];
   logic signed [15:0] pulses [16];
   logic signed [15:0] next_turns [16];
   logic signed [15:0] next_pulses [16];
   logic aw_taken, w_taken, next_aw_taken, next_w_taken;
   logic [11:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic over, under, next_over, next_under, clamp, next_clamp;
   logic [1:0] quad, next_quad;
   logic signed [15:0] next_torque, lim, comp;
   logic signed [23:0] level, upper, lower, eff, raw;
   logic [15:0] fixed_lim, ana_lim;
   logic ana_on;
   pos_entry_t next_pos;

   // Clamps a value into a closed range.
   function automatic logic signed [15:0] sat(input logic signed [31:0] v,
                                              input int lo, input int hi);
      if (v < lo) begin
         sat = 16'(lo);
      end else if (v > hi) begin
         sat = 16'(hi);
      end else begin
         sat = v[15:0];
      end
   endfunction

   // Byte-lane merge of a write into the old register image.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d, input logic [3:0] s);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            merge[8*i +: 8] = d[8*i +: 8];
         end
      end
   endfunction

   // Aligned and inside the map; anything else answers with an error.
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a[1:0] == 2'b00) &&
               (a <= OFS_STATUS || (a >= OFS_TABLE && a <= OFS_TABLE_END));
   endfunction

   // Register read image, shared by the read channel and write merging.
   function automatic logic [31:0] regval(input logic [11:0] a);
      regval = 32'h0000_0000;
      if (a >= OFS_TABLE && a <= OFS_TABLE_END) begin
         regval = a[2] ? {{16{pulses[a[6:3]][15]}}, pulses[a[6:3]]} :
                         {{16{turns[a[6:3]][15]}}, turns[a[6:3]]};
      end else begin
         unique case (a)
            OFS_CTRL: begin
               regval[CTRL_MODE_BIT] = cfg.torque_mode;
               regval[CTRL_SRC_LSB +: 2] = cfg.src;
               regval[CTRL_POS_MODE_BIT] = cfg.pos_index_lock;
               regval[CTRL_FUNC_LSB +: 5] = cfg.aux_func;
            end
            OFS_SPD_LIM: regval = {{16{cfg.spd_lim[15]}}, cfg.spd_lim};
            OFS_SPD_BIAS: regval = {16'h0000, cfg.spd_bias};
            OFS_SPD_COMM: regval = {{16{cfg.spd_comm[15]}}, cfg.spd_comm};
            OFS_TLIM: regval = {16'h0000, cfg.tlim[0]};
            OFS_TLIM + 12'h004: regval = {16'h0000, cfg.tlim[1]};
            OFS_TLIM + 12'h008: regval = {16'h0000, cfg.tlim[2]};
            OFS_TLIM + 12'h00C: regval = {16'h0000, cfg.tlim[3]};
            OFS_AIN_GAIN: regval = {16'h0000, cfg.ain_gain};
            OFS_POS_FREQ: regval = {16'h0000, cfg.pos_freq};
            OFS_POS_OFS: regval = {16'h0000, cfg.pos_offset};
            OFS_STATUS: begin
               regval[15:0] = torque_cmd;
               regval[STAT_OVER_BIT] = over;
               regval[STAT_UNDER_BIT] = under;
               regval[STAT_CLAMP_BIT] = clamp;
               regval[STAT_QUAD_LSB +: 2] = quad;
            end
            default: regval = 32'h0000_0000;
         endcase
      end
   endfunction

   assign s_axi_awready = !aw_taken && !s_axi_bvalid;
   assign s_axi_wready = !w_taken && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Bus slave and register file. Address and data may arrive in either
   // order; the write lands in the cycle the later of the two is taken.
   always_comb begin
      logic [11:0] wa;
      logic [31:0] m;
      logic [3:0] ix;
      wa = aw_taken ? aw_addr : s_axi_awaddr;
      m = merge(regval(wa), w_taken ? w_data : s_axi_wdata,
                w_taken ? w_strb : s_axi_wstrb);
      ix = wa[6:3];
      next_cfg = cfg;
      next_turns = turns;
      next_pulses = pulses;
      next_aw_taken = aw_taken || (s_axi_awvalid && s_axi_awready);
      next_w_taken = w_taken || (s_axi_wvalid && s_axi_wready);
      next_aw_addr = aw_taken ? aw_addr : s_axi_awaddr;
      next_w_data = w_taken ? w_data : s_axi_wdata;
      next_w_strb = w_taken ? w_strb : s_axi_wstrb;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (next_aw_taken && next_w_taken) begin
         next_aw_taken = 1'b0;
         next_w_taken = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
         if (mapped(wa) && wa >= OFS_TABLE) begin
            if (wa[2]) begin
               next_pulses[ix] = sat($signed(m[15:0]), -POS_MAX, POS_MAX);
            end else begin
               next_turns[ix] = sat($signed(m[15:0]), -POS_MAX, POS_MAX);
            end
         end else if (mapped(wa)) begin
            unique case (wa)
               OFS_CTRL: begin
                  next_cfg.torque_mode = m[CTRL_MODE_BIT];
                  if (m[CTRL_SRC_LSB +: 2] != 2'b11) begin
                     next_cfg.src = src_t'(m[CTRL_SRC_LSB +: 2]);
                  end
                  next_cfg.pos_index_lock = m[CTRL_POS_MODE_BIT];
                  next_cfg.aux_func = m[CTRL_FUNC_LSB +: 5];
               end
               OFS_SPD_LIM: next_cfg.spd_lim = sat($signed(m[15:0]), -SPD_MAX, SPD_MAX);
               OFS_SPD_BIAS: next_cfg.spd_bias = sat($signed(m[15:0]), 0, SPD_MAX);
               OFS_SPD_COMM: next_cfg.spd_comm = sat($signed(m[15:0]), -SPD_MAX, SPD_MAX);
               OFS_AIN_GAIN: next_cfg.ain_gain = m[15:0];
               OFS_POS_FREQ:
                  next_cfg.pos_freq = sat({16'h0000, m[15:0]}, POS_FREQ_MIN, POS_FREQ_MAX);
               OFS_POS_OFS: next_cfg.pos_offset = sat({16'h0000, m[15:0]}, 0, OFS_MAX);
               OFS_STATUS: next_cfg = cfg;
               default: next_cfg.tlim[wa[3:2]] = sat({16'h0000, m[15:0]}, 0, TLIM_MAX);
            endcase
         end
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = regval(s_axi_araddr);
         next_rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // Bus slave and register file state; the reset clears every pending answer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= '{src: SRC_ANALOG, tlim: {4{TLIM_RST}}, ain_gain: GAIN_RST,
                  pos_freq: POS_FREQ_RST, default: '0};
         turns <= '{default: 16'h0000};
         pulses <= '{default: 16'h0000};
         aw_taken <= 1'b0;
         w_taken <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         cfg <= next_cfg;
         turns <= next_turns;
         pulses <= next_pulses;
         aw_taken <= next_aw_taken;
         w_taken <= next_w_taken;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // Torque path. The speed correction is a plain proportional push back
   // into the window; it trades smoothness for a single-cycle answer.
   always_comb begin
      logic signed [31:0] prod;
      prod = 32'(drv.aux_analog_input) * $signed({16'h0000, cfg.ain_gain});
      unique case (cfg.src)
         SRC_ANALOG: level = 24'(drv.ai_speed_level);
         SRC_STORED: level = 24'(cfg.spd_lim);
         default: level = 24'(cfg.spd_comm);
      endcase
      upper = level + 24'(cfg.spd_bias);
      lower = -24'(cfg.spd_bias);
      next_over = 24'(drv.motor_speed) > upper;
      next_under = 24'(drv.motor_speed) < lower;
      comp = (cfg.aux_func == FUNC_TCOMP) ? drv.aux_analog_input : 16'sh0000;
      eff = 24'(drv.torque_ref) + 24'(comp);
      if (cfg.torque_mode && next_over) begin
         raw = (upper - 24'(drv.motor_speed)) <<< SPD_LOOP_SHIFT;
      end else if (cfg.torque_mode && next_under) begin
         raw = (lower - 24'(drv.motor_speed)) <<< SPD_LOOP_SHIFT;
      end else begin
         raw = eff;
      end
      // Quadrant 0..3 stands for I..IV from speed sign and torque sign.
      next_quad = {raw[23], drv.motor_speed[15] ^ raw[23]};
      fixed_lim = cfg.tlim[next_quad];
      ana_lim = sat(prod >>> GAIN_SHIFT, 0, TLIM_MAX);
      unique case (cfg.aux_func)
         FUNC_TLIM_POS: ana_on = (next_quad == 2'd0);
         FUNC_TLIM_NEG: ana_on = next_quad[1];
         FUNC_TLIM_REGEN: ana_on = next_quad[0];
         FUNC_TLIM_ALL: ana_on = 1'b1;
         default: ana_on = 1'b0;
      endcase
      lim = (ana_on && ana_lim < fixed_lim) ? ana_lim : fixed_lim;
      next_torque = sat(32'(raw), -int'(lim), int'(lim));
      next_clamp = 32'(next_torque) != 32'(raw);
      next_pos = '{turns: turns[pos_section], pulses: pulses[pos_section]};
   end

   // Torque command and status flags, registered so the regulator sees a clean word.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         torque_cmd <= 16'sh0000;
         over <= 1'b0;
         under <= 1'b0;
         clamp <= 1'b0;
         quad <= 2'b00;
         pos_entry <= '0;
      end else begin
         torque_cmd <= next_torque;
         over <= next_over;
         under <= next_under;
         clamp <= next_clamp;
         quad <= next_quad;
         pos_entry <= next_pos;
      end
   end

   // Configuration seen by the regulator and the positioning logic.
   assign torque_mode = cfg.torque_mode;
   assign pos_max_freq = cfg.pos_freq;
   assign pos_offset = cfg.pos_offset;
   assign pos_index_lock = cfg.pos_index_lock;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_window_pass: assert property (cfg.torque_mode && !next_over && !next_under
      && comp == 0 && !next_clamp |=> torque_cmd == $past(drv.torque_ref))
      else $error("torque in window differs from reference");
   a_over_push: assert property (cfg.torque_mode && next_over |=> torque_cmd <= 0)
      else $error("over speed gave positive torque");
   a_under_push: assert property (cfg.torque_mode && next_under |=> torque_cmd >= 0)
      else $error("under speed gave negative torque");
   a_limit_bound: assert property (1'b1 |=> torque_cmd <= $past(lim)
      && torque_cmd >= -$past(lim))
      else $error("torque beyond selected limit");
   a_fixed_quad: assert property (cfg.aux_func == 5'h00 |-> lim == cfg.tlim[next_quad])
      else $error("wrong quadrant limit");
   a_code12_quads: assert property (cfg.aux_func == FUNC_TLIM_NEG
      && !next_quad[1] |-> lim == fixed_lim)
      else $error("analog limit outside III and IV");
   a_code13_quads: assert property (cfg.aux_func == FUNC_TLIM_REGEN
      && !next_quad[0] |-> lim == fixed_lim)
      else $error("analog limit outside II and IV");
   a_tlim_range: assert property (cfg.tlim[0] <= TLIM_MAX && cfg.tlim[1] <= TLIM_MAX
      && cfg.tlim[2] <= TLIM_MAX && cfg.tlim[3] <= TLIM_MAX)
      else $error("torque limit above maximum");
   a_table_range: assert property ($changed(pulses[pos_section]) |->
      pulses[pos_section] <= POS_MAX && pulses[pos_section] >= -POS_MAX)
      else $error("pulse count out of range");
   a_freq_range: assert property (cfg.pos_freq >= POS_FREQ_MIN
      && cfg.pos_freq <= POS_FREQ_MAX)
      else $error("position frequency out of range");
endmodule

// file: testbench/motor_load_model.sv
/*
 Behavioural motor and encoder on the far side of the torque command.
 Assumes the bench sets the shaft speed; the model reports it one cycle later.
*/
`timescale 1ns/100ps
module motor_load_model
   import tsl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic signed [15:0] speed_set,
   output logic signed [15:0] motor_speed
);
   logic signed [15:0] next_motor_speed;
   // The shaft is taken as stiff, so the bench alone decides its speed.
   always_comb begin
      next_motor_speed = aresetn ? speed_set : 16'sh0000;
   end
   // A register gives the encoder the lag of one sample.
   always_ff @(posedge aclk) begin
      motor_speed <= next_motor_speed;
   end
endmodule

// file: testbench/tb_torque_speed_limit_position_cfg.sv
/*
 Self-checking bench of the torque and speed limit block: AXI4-Lite master
 tasks, the motor model and one task for each scenario.
 Assumes the package and the motor model are compiled first.
*/
`timescale 1ns/100ps
module tb_torque_speed_limit_position_cfg
   import tsl_pkg::*;
;
   logic aclk, awready, wready, bvalid, arready, rvalid, torque_mode, pos_index_lock;
   logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'hF, pos_section = 4'h0;
   logic [1:0] bresp, rresp;
   logic [15:0] pos_max_freq, pos_offset;
   logic signed [15:0] speed_set = 16'sh0000, tref = 16'sh0000, aux = 16'sh0000;
   logic signed [15:0] ai_level = 16'sh0000, motor_speed, torque_cmd;
   drive_in_t drv;
   pos_entry_t pos_entry;
   int err_total = 0, samples_checked = 0, cycles = 0;

   // The drive bundle joins the model's shaft speed to the bench's levels.
   assign drv = {motor_speed, tref, aux, ai_level};

   // Device under test and the motor it commands.
   torque_speed_limit_position_cfg i_torque_speed_limit_position_cfg (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drv(drv),
      .pos_section(pos_section), .torque_mode(torque_mode), .torque_cmd(torque_cmd),
      .pos_entry(pos_entry), .pos_max_freq(pos_max_freq), .pos_offset(pos_offset),
      .pos_index_lock(pos_index_lock));
   motor_load_model i_motor_load_model (.aclk(aclk), .aresetn(aresetn),
      .speed_set(speed_set), .motor_speed(motor_speed));

   // A 40 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // A hang is cut short well beyond the few hundred cycles the run needs.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         test_done();
      end
   end

   // One comparison, counted, reported at once on a difference.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Address and data are offered together and each is dropped once taken.
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_go, w_go, aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge aclk);
         aw_go = awready && !aw_done;
         w_go = wready && !w_done;
         @(posedge aclk);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
         aw_done = aw_done || aw_go;
         w_done = w_done || w_go;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      chk("bresp", 32'(er), 32'(bresp));
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   // Ready is sampled before the edge, so the edge itself carries the transfer.
   task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      chk("rdata", ed, rdata);
      chk("rresp", 32'(er), 32'(rresp));
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   // A write that must be accepted.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      axi_write(a, d, RESP_OKAY);
   endtask

   // Sets speed, torque and auxiliary level, then judges the torque command.
   task automatic run(input int sp, input int tr, input int ax, input int ex);
      @(posedge aclk);
      speed_set <= 16'(sp);
      tref <= 16'(tr);
      aux <= 16'(ax);
      repeat (3) @(posedge aclk);
      #1 chk("torque_cmd", 32'(ex), 32'(torque_cmd));
   endtask

   // Quadrant q (0 is I) by speed and torque sign, with a demand beyond mag.
   task automatic run_q(input int q, input int ax, input int mag);
      run((q == 1 || q == 2) ? -10 : 10, (q >= 2) ? -2500 : 2500, ax, (q >= 2) ? -mag : mag);
   endtask

   // Reset contents, then a bad address and a read-only place.
   task automatic t_reset_and_bad();
      axi_read(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
      for (int q = 0; q < 4; q++) axi_read(OFS_TLIM + 12'(4 * q), 32'(TLIM_RST), RESP_OKAY);
      axi_read(OFS_POS_FREQ, 32'(POS_FREQ_RST), RESP_OKAY);
      chk("torque_mode", 32'h0000_0000, 32'(torque_mode));
      axi_read(12'h040, 32'h0000_0000, RESP_SLVERR);
      axi_write(12'h002, 32'h0000_0001, RESP_SLVERR);
      axi_write(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
      axi_read(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
   endtask

   // Four separate limits, one per quadrant, ruling the speed regulator too.
   task automatic t_quadrants();
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_TLIM, 32'd5000);
      axi_read(OFS_TLIM, 32'd3000, RESP_OKAY);
      for (int q = 0; q < 4; q++) wr(OFS_TLIM + 12'(4 * q), 32'(100 * (q + 1)));
      for (int q = 0; q < 4; q++) run_q(q, 0, 100 * (q + 1));
   endtask

   // Every analog limit code against every quadrant, analog level below the fixed.
   task automatic t_analog();
      logic [3:0] m;
      for (int c = 0; c < 4; c++) begin
         m = (c == 0) ? 4'b0001 : (c == 1) ? 4'b1100 : (c == 2) ? 4'b1010 : 4'b1111;
         wr(OFS_CTRL, 32'(FUNC_TLIM_POS + 5'(c)) << CTRL_FUNC_LSB);
         for (int q = 0; q < 4; q++) run_q(q, 50, m[q] ? 50 : 100 * (q + 1));
      end
   endtask

   // Full scale at unity gain is rated torque; double gain doubles the limit.
   task automatic t_gain();
      for (int q = 0; q < 4; q++) wr(OFS_TLIM + 12'(4 * q), 32'd3000);
      wr(OFS_CTRL, 32'(FUNC_TLIM_ALL) << CTRL_FUNC_LSB);
      run_q(0, 1000, 1000);
      wr(OFS_AIN_GAIN, 32'h0000_0800);
      run_q(0, 100, 200);
      run_q(0, 1000, 2000);
      wr(OFS_AIN_GAIN, 32'(GAIN_RST));
   endtask

   // Compensation follows the input sign whatever the direction, then is limited.
   task automatic t_comp();
      wr(OFS_CTRL, 32'(FUNC_TCOMP) << CTRL_FUNC_LSB);
      run(10, 300, 100, 400);
      run(10, 300, -100, 200);
      run(-10, 300, 100, 400);
      run(10, 2900, 500, 3000);
   endtask

   // Window from minus bias to limit plus bias, edges included.
   task automatic t_window();
      wr(OFS_SPD_LIM, 32'd1000);
      wr(OFS_SPD_BIAS, 32'd200);
      wr(OFS_CTRL, 32'h0000_0003);
      chk("torque_mode", 32'h0000_0001, 32'(torque_mode));
      run(500, 300, 0, 300);
      run(1200, 300, 0, 300);
      run(1300, 300, 0, -800);
      axi_read(OFS_STATUS, 32'h0031_FCE0, RESP_OKAY);
      run(-300, -100, 0, 800);
      run(-200, -100, 0, -100);
   endtask

   // Each speed limit source; the undefined code leaves the old one in force.
   task automatic t_source();
      wr(OFS_SPD_BIAS, 32'd0);
      wr(OFS_SPD_COMM, 32'd300);
      ai_level <= 16'sd500;
      wr(OFS_CTRL, 32'h0000_0001);
      run(600, 300, 0, -800);
      wr(OFS_CTRL, 32'h0000_0005);
      run(600, 300, 0, -2400);
      wr(OFS_CTRL, 32'h0000_0003);
      run(600, 300, 0, 300);
      wr(OFS_CTRL, 32'h0000_0007);
      run(600, 300, 0, 300);
   endtask

   // Table ends and saturation, move frequency, offset and index lock mode.
   task automatic t_position();
      wr(OFS_TABLE, 32'd12000);
      wr(OFS_TABLE + 12'h004, 32'(-12000));
      wr(OFS_TABLE + 12'h078, 32'(-5));
      wr(OFS_TABLE + 12'h07C, 32'd1234);
      axi_read(OFS_TABLE + 12'h004, 32'hFFFF_D8F1, RESP_OKAY);
      pos_section <= 4'h0;
      repeat (2) @(posedge aclk);
      #1 chk("pos_entry", 32'h270F_D8F1, pos_entry);
      @(posedge aclk) pos_section <= 4'hF;
      repeat (2) @(posedge aclk);
      #1 chk("pos_entry", 32'hFFFB_04D2, pos_entry);
      wr(OFS_POS_FREQ, 32'd0);
      chk("pos_max_freq", 32'd1, 32'(pos_max_freq));
      wr(OFS_POS_FREQ, 32'd2000);
      chk("pos_max_freq", 32'd1000, 32'(pos_max_freq));
      wr(OFS_POS_OFS, 32'd20000);
      chk("pos_offset", 32'd9999, 32'(pos_offset));
      wstrb <= 4'h1;
      wr(OFS_POS_OFS, 32'h0000_0005);
      wstrb <= 4'hF;
      chk("pos_offset", 32'd9989, 32'(pos_offset));
      wr(OFS_CTRL, 32'h0000_0008);
      chk("pos_index_lock", 32'h0000_0001, 32'(pos_index_lock));
   endtask

   // Counts, verdict and the end of the run.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Reset for sixteen cycles, then every scenario in turn.
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_and_bad();
      t_quadrants();
      t_analog();
      t_gain();
      t_comp();
      t_window();
      t_source();
      t_position();
      test_done();
   end
endmodule
